// >>> rtl/ext_irq_sensitivity_port.sv
// external interrupt sensitivity control with three general purpose ports (A, B, F)
// assumes an AXI4-Lite master on clk, CPU interrupt level bits and vector fetch strobes
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`default_nettype none
`include "ext_irq_cfg.svh"
module ext_irq_sensitivity_port
   import ext_irq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [`ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic intLevelHi,
   input wire logic intLevelLo,
   input wire logic [3:0] vectorFetch,
   input wire byte_t portAIn,
   output byte_t portAOut,
   output byte_t portAOeN,
   input wire byte_t portBIn,
   output byte_t portBOut,
   output byte_t portBOeN,
   input wire byte_t portFIn,
   output byte_t portFOut,
   output byte_t portFOeN,
   output logic [3:0] extLineReq
);
   byte_t extInterruptSensitivity;
   logic [3:0] pending;
   logic [`ADDR_W-1:0] wrAddr;
   byte_t wrByte;
   logic wrByteEn;
   logic awHeld;
   logic wHeld;
   logic doWrite;
   logic wrMapped;
   logic next_awHeld;
   logic next_wHeld;
   logic next_bvalid;
   logic next_rvalid;
   logic levelOpen;
   logic sensWrite;
   byte_t sensNew;
   logic [2:0] portWr;
   logic [2:0][7:0] portIn;
   logic [2:0][7:0] portOut;
   logic [2:0][7:0] portOeN;
   logic [2:0][7:0] portLevel;
   logic [2:0][7:0] portPrev;
   logic [2:0][7:0] portDir;
   logic [2:0][7:0] portOpt;
   logic [2:0][7:0] portRead;
   logic [3:0][7:0] lineCur;
   logic [3:0][7:0] linePrev;
   logic [3:0][7:0] lineEn;
   logic [3:0] edgeHit;
   logic [3:0] levelHit;
   logic [3:0] lineClr;
   byte_t rdByte;
   logic rdOk;
   logic [1:0] rdPort;
   logic [1:0] rdReg;
   logic [1:0] wrPort;
   logic [1:0] wrReg;
   sens_mode_e sensA;
   sens_mode_e sensB;
   logic polA;
   logic polB;

   assign sensB = sens_mode_e'(extInterruptSensitivity[`SENS_B_MSB:`SENS_B_LSB]);
   assign sensA = sens_mode_e'(extInterruptSensitivity[`SENS_A_MSB:`SENS_A_LSB]);
   assign polB = extInterruptSensitivity[`POL_B_BIT];
   assign polA = extInterruptSensitivity[`POL_A_BIT];

   // write channel: address and data are taken independently, in either order
   assign doWrite = awHeld && wHeld;
   assign wrPort = wrAddr[`PORT_SEL_MSB:`PORT_SEL_LSB];
   assign wrReg = wrAddr[`REG_SEL_MSB:`REG_SEL_LSB];
   assign wrMapped = (wrAddr == `OFF_SENS) || (wrAddr == `OFF_PEND) ||
      (wrPort != 2'h0 && wrReg != 2'h3 && wrAddr[1:0] == 2'h0 &&
       wrAddr[`ADDR_W-1:`PORT_SEL_MSB+1] == '0);

   always_comb begin
      next_awHeld = awHeld;
      next_wHeld = wHeld;
      next_bvalid = s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
         next_awHeld = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_wHeld = 1'b1;
      end
      if (doWrite) begin
         next_awHeld = 1'b0;
         next_wHeld = 1'b0;
         next_bvalid = 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         s_axi_bvalid <= next_bvalid;
         // one write at a time: no new address or data until the response is gone
         s_axi_awready <= !next_awHeld && !next_bvalid && !doWrite;
         s_axi_wready <= !next_wHeld && !next_bvalid && !doWrite;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wrAddr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         wrAddr <= s_axi_awaddr;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wrByte <= '0;
         wrByteEn <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wrByte <= s_axi_wdata[7:0];
         wrByteEn <= s_axi_wstrb[0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_bresp <= `RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   // sensitivity fields only open at CPU interrupt level 3
   assign levelOpen = intLevelHi && intLevelLo;
   assign sensWrite = doWrite && wrByteEn && wrAddr == `OFF_SENS && levelOpen;
   // reserved bits 1:0 are kept at zero whatever software writes
   assign sensNew = wrByte & `SENS_WRITABLE;

   always_ff @(posedge clk) begin
      if (rst) begin
         extInterruptSensitivity <= `SENS_RESET;
      end else if (sensWrite) begin
         extInterruptSensitivity <= sensNew;
      end
   end

   // a write that changes a line's sensitivity discards its pending request
   always_comb begin
      lineClr[0] = sensWrite && (sensNew[`SENS_A_MSB:`POL_A_BIT] !=
         extInterruptSensitivity[`SENS_A_MSB:`POL_A_BIT]);
      lineClr[1] = sensWrite && (sensNew[`SENS_A_MSB:`SENS_A_LSB] !=
         extInterruptSensitivity[`SENS_A_MSB:`SENS_A_LSB]);
      lineClr[2] = sensWrite && (sensNew[`SENS_B_MSB:`POL_B_BIT] !=
         extInterruptSensitivity[`SENS_B_MSB:`POL_B_BIT]);
      lineClr[3] = sensWrite && (sensNew[`SENS_B_MSB:`SENS_B_LSB] !=
         extInterruptSensitivity[`SENS_B_MSB:`SENS_B_LSB]);
   end

   // ports: index 0 is A, 1 is B, 2 is F
   assign portIn[0] = portAIn;
   assign portIn[1] = portBIn;
   assign portIn[2] = portFIn;
   assign portAOut = portOut[0];
   assign portBOut = portOut[1];
   assign portFOut = portOut[2];
   assign portAOeN = portOeN[0];
   assign portBOeN = portOeN[1];
   assign portFOeN = portOeN[2];

   for (genvar p = 0; p < 3; p++) begin : g_port
      assign portWr[p] = doWrite && wrByteEn && wrMapped && wrPort == 2'(p + 1);
      gp_port_pins u_pins (
         .clk(clk),
         .rst(rst),
         .wrEn(portWr[p]),
         .wrSel(wrReg),
         .wrData(wrByte),
         .pinIn(portIn[p]),
         .pinOut(portOut[p]),
         .pinOeN(portOeN[p]),
         .pinLevel(portLevel[p]),
         .pinPrev(portPrev[p]),
         .dir(portDir[p]),
         .opt(portOpt[p]),
         .readData(portRead[p])
      );
   end

   // group pins per line; a pin joins its line only as an input with option set
   always_comb begin
      lineCur[0] = portLevel[0];
      linePrev[0] = portPrev[0];
      lineEn[0] = ~portDir[0] & portOpt[0] & `LINE0_MASK;
      lineCur[1] = portLevel[2];
      linePrev[1] = portPrev[2];
      lineEn[1] = ~portDir[2] & portOpt[2] & `LINE1_MASK;
      lineCur[2] = portLevel[1];
      linePrev[2] = portPrev[1];
      lineEn[2] = ~portDir[1] & portOpt[1] & `LINE2_MASK;
      lineCur[3] = portLevel[1];
      linePrev[3] = portPrev[1];
      lineEn[3] = ~portDir[1] & portOpt[1] & `LINE3_MASK;
   end

   // inverting the sampled pin turns low into high and swaps rising with falling,
   // while leaving both-edges alone, which is exactly the polarity behaviour
   for (genvar l = 0; l < 4; l++) begin : g_line
      sens_mode_e mode;
      logic inv;
      byte_t cur;
      byte_t prev;
      byte_t hit;
      assign mode = (l < 2) ? sensA : sensB;
      assign inv = (l == 0) ? polA : ((l == 2) ? polB : 1'b0);
      assign cur = lineCur[l] ^ {8{inv}};
      assign prev = linePrev[l] ^ {8{inv}};
      always_comb begin
         unique case (mode)
            SENS_RISE: hit = cur & ~prev;
            SENS_FALL: hit = ~cur & prev;
            SENS_BOTH: hit = cur ^ prev;
            SENS_FALL_LOW: hit = ~cur & prev;
         endcase
      end
      assign edgeHit[l] = |(hit & lineEn[l]);
      assign levelHit[l] = (mode == SENS_FALL_LOW) && |(~cur & lineEn[l]);

      // a new edge in the same cycle as a fetch or clear still wins
      always_ff @(posedge clk) begin
         if (rst) begin
            pending[l] <= 1'b0;
            extLineReq[l] <= 1'b0;
         end else begin
            pending[l] <= edgeHit[l] ||
               (pending[l] && !vectorFetch[l] && !lineClr[l]);
            extLineReq[l] <= edgeHit[l] || levelHit[l] ||
               (pending[l] && !vectorFetch[l] && !lineClr[l]);
         end
      end
   end

   // read channel
   assign rdPort = s_axi_araddr[`PORT_SEL_MSB:`PORT_SEL_LSB];
   assign rdReg = s_axi_araddr[`REG_SEL_MSB:`REG_SEL_LSB];

   always_comb begin
      rdByte = '0;
      rdOk = 1'b0;
      if (s_axi_araddr == `OFF_SENS) begin
         rdByte = extInterruptSensitivity;
         rdOk = 1'b1;
      end else if (s_axi_araddr == `OFF_PEND) begin
         rdByte = {4'h0, extLineReq};
         rdOk = 1'b1;
      end else if (rdPort != 2'h0 && s_axi_araddr[1:0] == 2'h0 &&
                   s_axi_araddr[`ADDR_W-1:`PORT_SEL_MSB+1] == '0) begin
         rdOk = 1'b1;
         unique case (rdReg)
            `REG_DATA: rdByte = portRead[rdPort - 2'h1];
            `REG_DIR: rdByte = portDir[rdPort - 2'h1];
            `REG_OPT: rdByte = portOpt[rdPort - 2'h1];
            default: rdOk = 1'b0;
         endcase
      end
   end

   always_comb begin
      next_rvalid = s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_rvalid <= next_rvalid;
         s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_rdata <= '0;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rdata <= {24'h0, rdByte};
         s_axi_rresp <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/ext_irq_cfg.svh
// register offsets, field positions, reset values and misc constants
// assumes an includer that wants plain macros; definitions only
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH

`define ADDR_W 8
`define OFF_SENS 8'h00
`define OFF_PEND 8'h04
`define PORT_SEL_LSB 4
`define PORT_SEL_MSB 5
`define REG_SEL_LSB 2
`define REG_SEL_MSB 3
`define REG_DATA 2'h0
`define REG_DIR 2'h1
`define REG_OPT 2'h2
`define PORT_A_SEL 2'h1
`define PORT_B_SEL 2'h2
`define PORT_F_SEL 2'h3

`define SENS_RESET 8'h00
`define SENS_B_MSB 7
`define SENS_B_LSB 6
`define POL_B_BIT 5
`define SENS_A_MSB 4
`define SENS_A_LSB 3
`define POL_A_BIT 2
`define SENS_WRITABLE 8'hfc

`define PIN_RESET 8'h00
`define SYNC_RESET 8'hff
`define LINE0_MASK 8'h0f
`define LINE1_MASK 8'h07
`define LINE2_MASK 8'h0f
`define LINE3_MASK 8'h10

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> rtl/ext_irq_pkg.sv
// types shared by the sensitivity controller and its port stage
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package ext_irq_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {
      SENS_FALL_LOW = 2'h0,
      SENS_RISE = 2'h1,
      SENS_FALL = 2'h2,
      SENS_BOTH = 2'h3
   } sens_mode_e;
endpackage
`default_nettype wire

// >>> rtl/gp_port_pins.sv
// one eight-pin general purpose port: direction, option, output latch, input sampling
// assumes pin inputs synchronous to clk; writes come as single-cycle enables
`default_nettype none
`include "ext_irq_cfg.svh"
module gp_port_pins
   import ext_irq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wrEn,
   input wire logic [1:0] wrSel,
   input wire byte_t wrData,
   input wire byte_t pinIn,
   output byte_t pinOut,
   output byte_t pinOeN,
   output byte_t pinLevel,
   output byte_t pinPrev,
   output byte_t dir,
   output byte_t opt,
   output byte_t readData
);
   byte_t syncFirst;

   // writing the latch never disturbs an input pin: it only drives once dir is 1
   always_ff @(posedge clk) begin
      if (rst) begin
         pinOut <= `PIN_RESET;
      end else if (wrEn && wrSel == `REG_DATA) begin
         pinOut <= wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dir <= `PIN_RESET;
         pinOeN <= ~`PIN_RESET;
      end else if (wrEn && wrSel == `REG_DIR) begin
         dir <= wrData;
         pinOeN <= ~wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         opt <= `PIN_RESET;
      end else if (wrEn && wrSel == `REG_OPT) begin
         opt <= wrData;
      end
   end

   // two-stage sampling, then one more stage kept only for edge comparison
   always_ff @(posedge clk) begin
      if (rst) begin
         syncFirst <= `SYNC_RESET;
         pinLevel <= `SYNC_RESET;
         pinPrev <= `SYNC_RESET;
      end else begin
         syncFirst <= pinIn;
         pinLevel <= syncFirst;
         pinPrev <= pinLevel;
      end
   end

   // bit x of every register maps to pin x
   always_comb begin
      readData = (dir & pinOut) | (~dir & pinLevel);
   end
endmodule
`default_nettype wire

// >>> testbench/ext_irq_props.sv
// bus and pin-output assertions for the sensitivity controller
// assumes it is bound to the top module and sees only its ports
`default_nettype none
module ext_irq_props
   import ext_irq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire byte_t portAOut,
   input wire byte_t portAOeN,
   input wire byte_t portBOut,
   input wire byte_t portBOeN,
   input wire byte_t portFOut,
   input wire byte_t portFOeN
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   chk_b_refuse:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   chk_ar_refuse:
      assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   chk_b_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_r_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   chk_w_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> ##1 s_axi_bvalid)
      else $error("write response late");
   chk_r_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_b_release:
      assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   chk_rdata_width:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data wider than a byte");
   chk_pins_by_write:
      assert property ($changed({portAOut, portAOeN, portBOut, portBOeN, portFOut, portFOeN})
         |-> $rose(s_axi_bvalid))
      else $error("pin drive changed without a write");
endmodule
bind ext_irq_sensitivity_port ext_irq_props props (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .portAOut, .portAOeN,
   .portBOut, .portBOeN, .portFOut, .portFOeN);
`default_nettype wire

// >>> testbench/pin_env.sv
// board side of one eight-pin port: outside drivers meet the device's own drive
// assumes active-low output enable; where the device drives, its level wins
`default_nettype none
module pin_env
   import ext_irq_pkg::*;
(
   input wire byte_t drv,
   input wire byte_t out,
   input wire byte_t oeN,
   output var byte_t pin
);
   timeunit 1ns;
   timeprecision 1ns;
   assign pin = (out & ~oeN) | (drv & oeN);
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the sensitivity controller and its three ports
// assumes the checker binds itself and pin_env stands for the board
`default_nettype none
`include "ext_irq_cfg.svh"
module tb_top
   import ext_irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [3:0] vectorFetch = 4'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, intLevelHi = 1'h0, intLevelLo = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [3:0] extLineReq;
   byte_t portAIn, portAOut, portAOeN, portBIn, portBOut, portBOeN;
   byte_t portFIn, portFOut, portFOeN, d, k, v;
   byte_t drvA = 8'h00, drvB = 8'h00, drvF = 8'h00;
   int mismatches = 0, nChecks = 0, cyc = 0, pe;
   always #20 clk = ~clk;
   ext_irq_sensitivity_port dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .intLevelHi, .intLevelLo, .vectorFetch,
      .portAIn, .portAOut, .portAOeN, .portBIn, .portBOut, .portBOeN, .portFIn, .portFOut,
      .portFOeN, .extLineReq);
   pin_env envA (.drv(drvA), .out(portAOut), .oeN(portAOeN), .pin(portAIn));
   pin_env envB (.drv(drvB), .out(portBOut), .oeN(portBOeN), .pin(portBIn));
   pin_env envF (.drv(drvF), .out(portFOut), .oeN(portFOeN), .pin(portFIn));
   task automatic results;
      if (mismatches == 0 && nChecks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // the whole run needs about 2300 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nChecks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic axiW(input logic [7:0] a, input byte_t dt, input logic [1:0] er);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, dt};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk("bresp", er, s_axi_bresp);
      repeat (2) @(posedge clk);
   endtask
   task automatic axiR(input logic [7:0] a, input byte_t e, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk("rdata", {24'h0, e}, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask
   task automatic setLvl(input bit ok);
      @(posedge clk);
      {intLevelHi, intLevelLo} <= ok ? 2'h3 : 2'($urandom % 3);
   endtask
   task automatic fetch(input int l);
      @(posedge clk);
      vectorFetch <= 4'(1 << l);
      @(posedge clk);
      vectorFetch <= 4'h0;
      repeat (3) @(posedge clk);
   endtask
   // other pins of the port toggle at random: they are not enabled and must not count
   task automatic setPin(input int l, input bit b);
      byte_t r;
      r = byte_t'($urandom);
      @(posedge clk);
      if (l == 0) drvA <= {r[7:1], b};
      if (l == 1) drvF <= {r[7:1], b};
      if (l == 2) drvB <= {r[7:1], b};
      if (l == 3) drvB <= {r[7:5], b, r[3:0]};
      repeat (6) @(posedge clk);
   endtask
   initial begin
      void'($urandom(19));
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      chk("oeN", 8'hff, portAOeN);
      chk("req", 4'h0, extLineReq);
      axiR(8'h00, 8'h00, `RESP_OKAY);
      axiW(8'h18, 8'h01, `RESP_OKAY);
      axiW(8'h28, 8'h11, `RESP_OKAY);
      axiW(8'h38, 8'h01, `RESP_OKAY);
      axiR(8'h28, 8'h11, `RESP_OKAY);
      setLvl(1);
      for (int l = 0; l < 4; l++) begin
         for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 2; p++) begin
               for (int r = 0; r < 2; r++) begin
                  pe = (l % 2 == 0) ? p : 0;
                  v = (l < 2) ? 8'((m << 3) | (p << 2)) : 8'((m << 6) | (p << 5));
                  axiW(8'h00, v, `RESP_OKAY);
                  axiR(8'h00, v, `RESP_OKAY);
                  setPin(l, r == 0);
                  fetch(l);
                  setPin(l, r == 1);
                  chk("req", (m == 3) || ((m == 1) != (r == pe)), extLineReq[l]);
                  fetch(l);
                  chk("req", m == 0 && r == pe, extLineReq[l]);
               end
            end
         end
      end
      axiW(8'h00, 8'h40, `RESP_OKAY);
      setPin(3, 1'h0);
      setPin(3, 1'h1);
      chk("req", 1'h1, extLineReq[3]);
      setLvl(0);
      axiW(8'h00, byte_t'($urandom) & 8'h3c | 8'h80, `RESP_OKAY);
      axiR(8'h00, 8'h40, `RESP_OKAY);
      chk("req", 1'h1, extLineReq[3]);
      setLvl(1);
      axiW(8'h00, 8'h7c, `RESP_OKAY);
      chk("req", 1'h1, extLineReq[3]);
      axiW(8'h00, 8'hc0, `RESP_OKAY);
      chk("req", 1'h0, extLineReq[3]);
      d = byte_t'($urandom);
      k = byte_t'($urandom);
      axiW(8'h30, d, `RESP_OKAY);
      chk("pinF", drvF, portFIn);
      axiR(8'h30, drvF, `RESP_OKAY);
      axiW(8'h34, k, `RESP_OKAY);
      axiR(8'h34, k, `RESP_OKAY);
      v = (d & k) | (drvF & ~k);
      chk("pinF", v, portFIn);
      chk("oeN", byte_t'(~k), portFOeN);
      axiR(8'h30, v, `RESP_OKAY);
      // port A stays input: the latch moves, the pin and its read do not
      axiW(8'h10, d, `RESP_OKAY);
      chk("outA", d, portAOut);
      chk("oeN", 8'hff, portAOeN);
      axiR(8'h10, drvA, `RESP_OKAY);
      // port B: latch first, then direction, so the pin never shows a stale level
      axiW(8'h20, k, `RESP_OKAY);
      axiW(8'h24, d, `RESP_OKAY);
      v = (k & d) | (drvB & ~d);
      chk("outB", k, portBOut);
      chk("oeN", byte_t'(~d), portBOeN);
      chk("pinB", v, portBIn);
      axiR(8'h20, v, `RESP_OKAY);
      axiW(8'h40, 8'h5a, `RESP_SLVERR);
      axiR(8'h42, 8'h00, `RESP_SLVERR);
      rst <= 1'h1;
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      chk("oeN", 8'hff, portFOeN);
      chk("oeN", 8'hff, portBOeN);
      chk("outA", 8'h00, portAOut);
      axiR(8'h00, 8'h00, `RESP_OKAY);
      results();
   end
endmodule
`default_nettype wire
